// >>> hw/hbs_pkg.sv
// hbs_pkg: constants shared by the half-bridge serial command port ends
// assumes a 10 MHz system clock on both ends
`default_nettype none
package hbs_pkg;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int WORD_BITS       = 16;
	localparam int CNT_W           = 5;
	localparam int CH_NUM          = 6;
	// control word fields
	localparam int BIT_CLEAR       = 0;
	localparam int BIT_DRV_LO      = 1;
	localparam int BIT_DRV_HI      = 12;
	localparam int BIT_OC_DELAY    = 13;
	localparam int BIT_UL_SHUT     = 14;
	localparam int BIT_OV_LOCK     = 15;
	// status word fields
	localparam int BIT_THERMAL     = 0;
	localparam int BIT_OVERLOAD    = 13;
	localparam int BIT_UNDERLOAD   = 14;
	localparam int BIT_SUPPLY      = 15;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// timing
	localparam int DEAD_TIME_NS    = 1500;
	localparam int DEAD_CYC        = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CS_HIGH_NS      = 5000;
	localparam int CS_HIGH_CYC     = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_DIV        = 16;
	localparam int SETUP_CYC       = 2;
	// host command register offsets
	localparam logic [1:0] ADDR_TX     = 2'h0;
	localparam logic [1:0] ADDR_CTRL   = 2'h1;
	localparam logic [1:0] ADDR_RX     = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;
endpackage
`default_nettype wire

// >>> hw/hbs_link_if.sv
// hbs_link_if: serial link between host and driver device
// the interface resolves the shared serial-out wire from sdo_oe, reading low when released
`default_nettype none
interface hbs_link_if;
	logic enable;
	logic chip_select_n;
	logic sclk;
	logic sdi;
	logic sdo_out;
	logic sdo_oe;
	logic sdo;
	assign sdo = sdo_oe ? sdo_out : 1'b0;
	modport device (input enable, chip_select_n, sclk, sdi, output sdo_out, sdo_oe);
	modport host (output enable, chip_select_n, sclk, sdi, input sdo);
endinterface
`default_nettype wire

// >>> hw/hbs_device.sv
// hbs_device: serial command port of the six-channel half-bridge driver
// assumes link pins are asynchronous to clock; fault flags come from analog logic
//
// The address map and the strobed register port were chosen for this implementation.
`default_nettype none
module hbs_device
	import hbs_pkg::*;
(
	// system
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// link
	hbs_link_if.device       link,
	// fault sources
	input  wire logic        thermal_warning_in,
	input  wire logic        supply_fail_in,
	input  wire logic        underload_in,
	input  wire logic        overload_in,
	// driver outputs
	output logic [5:0]       high_side_output,
	output logic [5:0]       low_side_output,
	output logic             overvoltage_lockout_enable,
	output logic             underload_shutdown_enable,
	output logic             overcurrent_delay_select
);
	logic [1:0]  en_sync_reg;
	logic [1:0]  cs_sync_reg;
	logic [1:0]  sck_sync_reg;
	logic [1:0]  sdi_sync_reg;
	logic        cs_prev_reg;
	logic        sck_prev_reg;
	logic [15:0] shift_reg;
	logic [15:0] status_shift_reg;
	logic [CNT_W-1:0] bit_cnt_reg;
	logic        seen_word_reg;
	logic [15:0] ctrl_reg;
	logic        thermal_reg;
	logic        supply_reg;
	logic        underload_reg;
	logic        overload_reg;
	logic        sdo_reg;
	logic        sdo_oe_reg;
	logic        rst_all;
	logic        sel;
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_rise;
	logic        cs_fall;
	logic        frame_ok;
	logic [15:0] status_word;

	// synchronisers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			en_sync_reg  <= 2'h0;
			cs_sync_reg  <= 2'h3;
			sck_sync_reg <= 2'h0;
			sdi_sync_reg <= 2'h0;
		end else begin
			en_sync_reg  <= {en_sync_reg[0], link.enable};
			cs_sync_reg  <= {cs_sync_reg[0], link.chip_select_n};
			sck_sync_reg <= {sck_sync_reg[0], link.sclk};
			sdi_sync_reg <= {sdi_sync_reg[0], link.sdi};
		end
	end

	assign rst_all  = sys_rst | ~en_sync_reg[1];
	assign sel      = ~cs_sync_reg[1];
	assign sck_rise = sel & sck_sync_reg[1] & ~sck_prev_reg;
	assign sck_fall = sel & ~sck_sync_reg[1] & sck_prev_reg;
	assign cs_rise  = cs_sync_reg[1] & ~cs_prev_reg;
	assign cs_fall  = ~cs_sync_reg[1] & cs_prev_reg;
	assign frame_ok = seen_word_reg && (bit_cnt_reg == 5'h00);

	always_comb begin
		status_word = {supply_reg, underload_reg, overload_reg,
			12'h000, thermal_reg};
		for (int i = 0; i < CH_NUM; i++) begin
			status_word[2*i+1] = low_side_output[i];
			status_word[2*i+2] = high_side_output[i];
		end
	end

	always_ff @(posedge clock) begin
		if (rst_all) begin
			cs_prev_reg  <= 1'b1;
			sck_prev_reg <= 1'b0;
		end else begin
			cs_prev_reg  <= cs_sync_reg[1];
			sck_prev_reg <= sck_sync_reg[1];
		end
	end

	// input shifting and edge counting
	always_ff @(posedge clock) begin
		if (rst_all || cs_fall) begin
			shift_reg     <= 16'h0000;
			bit_cnt_reg   <= 5'h00;
			seen_word_reg <= 1'b0;
		end else if (sck_fall) begin
			shift_reg <= {sdi_sync_reg[1], shift_reg[15:1]};
			if (bit_cnt_reg == 5'(WORD_BITS - 1)) begin
				bit_cnt_reg   <= 5'h00;
				seen_word_reg <= 1'b1;
			end else begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			end
		end
	end

	// output shifting, daisy chain refill from input
	always_ff @(posedge clock) begin
		if (rst_all) begin
			status_shift_reg <= 16'h0000;
			sdo_reg          <= 1'b0;
			sdo_oe_reg       <= 1'b0;
		end else begin
			sdo_oe_reg <= sel;
			if (cs_fall) begin
				status_shift_reg <= status_word;
				sdo_reg          <= 1'b0;
			end else if (sck_rise) begin
				sdo_reg <= status_shift_reg[0];
				status_shift_reg <= {1'b0, status_shift_reg[15:1]};
			end else if (sck_fall && bit_cnt_reg == 5'(WORD_BITS - 1)) begin
				status_shift_reg <= {sdi_sync_reg[1], shift_reg[15:1]};
			end
		end
	end

	// control latch
	always_ff @(posedge clock) begin
		if (rst_all) begin
			ctrl_reg <= CTRL_RESET;
		end else if (cs_rise && frame_ok) begin
			ctrl_reg <= shift_reg;
		end
	end

	// latched faults, set wins over clear
	always_ff @(posedge clock) begin
		if (rst_all) begin
			thermal_reg   <= 1'b0;
			supply_reg    <= 1'b0;
			underload_reg <= 1'b0;
			overload_reg  <= 1'b0;
		end else begin
			if (cs_rise && frame_ok && shift_reg[BIT_CLEAR]) begin
				thermal_reg   <= thermal_warning_in;
				supply_reg    <= supply_fail_in;
				underload_reg <= underload_in;
				overload_reg  <= overload_in;
			end else begin
				thermal_reg   <= thermal_reg | thermal_warning_in;
				supply_reg    <= supply_reg | supply_fail_in;
				underload_reg <= underload_reg | underload_in;
				overload_reg  <= overload_reg | overload_in;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst_all) begin
			overvoltage_lockout_enable <= 1'b0;
			underload_shutdown_enable  <= 1'b0;
			overcurrent_delay_select   <= 1'b0;
		end else begin
			overvoltage_lockout_enable <= ctrl_reg[BIT_OV_LOCK];
			underload_shutdown_enable  <= ctrl_reg[BIT_UL_SHUT];
			overcurrent_delay_select   <= ctrl_reg[BIT_OC_DELAY];
		end
	end

	// per half-bridge dead time
	genvar g;
	generate
		for (g = 0; g < CH_NUM; g++) begin : g_bridge
			logic [4:0] dead_cnt_reg;
			logic       want_lo;
			logic       want_hi;
			assign want_lo = ctrl_reg[2*g+1];
			assign want_hi = ctrl_reg[2*g+2];
			always_ff @(posedge clock) begin
				if (rst_all) begin
					dead_cnt_reg <= 5'h00;
					low_side_output[g]  <= 1'b0;
					high_side_output[g] <= 1'b0;
				end else begin
					if ((low_side_output[g] && !want_lo) ||
						(high_side_output[g] && !want_hi)) begin
						dead_cnt_reg <= 5'(DEAD_CYC);
					end else if (dead_cnt_reg != 5'h00) begin
						dead_cnt_reg <= dead_cnt_reg - 5'h01;
					end
					low_side_output[g]  <= want_lo && (low_side_output[g] ||
						(!high_side_output[g] && dead_cnt_reg == 5'h00));
					high_side_output[g] <= want_hi && (high_side_output[g] ||
						(!low_side_output[g] && dead_cnt_reg == 5'h00));
				end
			end
		end
	endgenerate

	assign link.sdo_out = sdo_reg;
	assign link.sdo_oe  = sdo_oe_reg;
endmodule
`default_nettype wire

// >>> hw/hbs_host.sv
// hbs_host: host end, issues one 16-bit frame per command write
// assumes software waits for busy low before writing the next word
`default_nettype none
module hbs_host
	import hbs_pkg::*;
(
	// system
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// command port
	input  wire logic [1:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata,
	// link
	hbs_link_if.host         link
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_GAP   = 4'b1000
	} hbs_state_type;

	hbs_state_type state_reg;
	logic [15:0] tx_reg;
	logic [15:0] rx_reg;
	logic        en_reg;
	logic        cs_n_reg;
	logic        sck_reg;
	logic        sdi_reg;
	logic [1:0]  sdo_sync_reg;
	logic [5:0]  cnt_reg;
	logic [4:0]  bits_reg;

	always_ff @(posedge clock) begin
		sdo_sync_reg <= {sdo_sync_reg[0], link.sdo};
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			unique case (addr)
				ADDR_TX:     rdata <= tx_reg;
				ADDR_CTRL:   rdata <= {15'h0000, en_reg};
				ADDR_RX:     rdata <= rx_reg;
				ADDR_STATUS: rdata <= {15'h0000, state_reg != ST_IDLE};
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			en_reg <= 1'b0;
		end else if (wr && addr == ADDR_CTRL) begin
			en_reg <= wdata[0];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			tx_reg    <= 16'h0000;
			rx_reg    <= 16'h0000;
			cs_n_reg  <= 1'b1;
			sck_reg   <= 1'b0;
			sdi_reg   <= 1'b0;
			cnt_reg   <= 6'h00;
			bits_reg  <= 5'h00;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (wr && addr == ADDR_TX && en_reg) begin
						tx_reg    <= wdata;
						sdi_reg   <= wdata[0];
						cs_n_reg  <= 1'b0;
						cnt_reg   <= 6'h00;
						bits_reg  <= 5'h00;
						state_reg <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == 6'(SETUP_CYC - 1)) begin
						cnt_reg   <= 6'h00;
						state_reg <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == 6'(SCLK_DIV / 2 - 1)) begin
						sck_reg <= 1'b1;
						// next bit moves at the rise, so it stands across the sampling fall
						sdi_reg <= tx_reg[0];
					end else if (cnt_reg == 6'(SCLK_DIV - 1)) begin
						cnt_reg <= 6'h00;
						sck_reg <= 1'b0;
						rx_reg  <= {sdo_sync_reg[1], rx_reg[15:1]};
						tx_reg  <= {1'b0, tx_reg[15:1]};
						bits_reg <= bits_reg + 5'h01;
						if (bits_reg == 5'(WORD_BITS - 1)) begin
							state_reg <= ST_GAP;
						end
					end
				end
				ST_GAP: begin
					cs_n_reg <= 1'b1;
					cnt_reg  <= cnt_reg + 6'h01;
					if (cnt_reg == 6'(CS_HIGH_CYC)) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign link.enable        = en_reg;
	assign link.chip_select_n = cs_n_reg;
	assign link.sclk          = sck_reg;
	assign link.sdi           = sdi_reg;
endmodule
`default_nettype wire

// >>> verif/hbs_link_monitor.sv
// hbs_link_monitor: checks on the serial link between host and device
// assumes both ends run on clock with synchronous sys_rst
`default_nettype none
module hbs_link_monitor
	import hbs_pkg::*;
(
	// system
	input wire logic clock,
	input wire logic sys_rst,
	// link
	input wire logic enable,
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo_oe
);
	int   gap_reg;
	int   edge_reg;
	logic seen_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clock) begin
		if (sys_rst || !chip_select_n)
			gap_reg <= 0;
		else if (gap_reg < 99)
			gap_reg <= gap_reg + 1;
	end
	always_ff @(posedge clock) begin
		if (sys_rst || chip_select_n)
			edge_reg <= 0;
		else if ($rose(sclk))
			edge_reg <= edge_reg + 1;
	end
	always_ff @(posedge clock) begin
		if (sys_rst)
			seen_reg <= 1'b0;
		else if ($rose(chip_select_n))
			seen_reg <= 1'b1;
	end
	a_frame_sixteen: assert property ($rose(chip_select_n) |-> edge_reg == WORD_BITS)
		else $error("frame length not sixteen");
	a_select_gap: assert property ($fell(chip_select_n) && seen_reg |-> gap_reg >= CS_HIGH_CYC)
		else $error("select high time too short");
	a_clock_idle: assert property (chip_select_n && $past(chip_select_n) |-> $stable(sclk))
		else $error("serial clock moved while deselected");
	a_input_hold: assert property ($fell(sclk) |-> $stable(sdi) ##1 $stable(sdi))
		else $error("serial input moved at falling clock");
	a_out_released: assert property (chip_select_n [*4] |-> !sdo_oe)
		else $error("serial output driven while deselected");
	a_out_driven: assert property ((enable && !chip_select_n) [*6] |-> sdo_oe)
		else $error("serial output not driven while selected");
	a_asleep_quiet: assert property ((!enable) [*4] |-> !sdo_oe)
		else $error("serial output driven while disabled");
	a_enable_first: assert property ($fell(chip_select_n) |-> enable && $past(enable))
		else $error("select lowered without enable");
	c_frame: cover property ($rose(chip_select_n));
	c_drive: cover property ($rose(sdo_oe));
	c_sleep: cover property ($fell(enable));
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// tb_top: host and device joined by one link, a second device on a bench-driven link
// assumes a 10 MHz clock and synchronous active-high reset
`default_nettype none
module tb_top
	import hbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic [1:0]  addr = 2'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic [3:0]  fault = 4'h0;
	logic [5:0]  hi, lo, hi_b, lo_b;
	logic [2:0]  opt;
	logic [11:0] side_q = 12'h000;
	logic [31:0] so_bits;
	wire  [11:0] sides = {hi, lo};
	int          errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          off_t[12];
	hbs_link_if link ();
	hbs_link_if link_b ();
	hbs_host u_hbs_host (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .link(link.host));
	hbs_device u_hbs_device (.clock(clock), .sys_rst(sys_rst), .link(link.device),
		.thermal_warning_in(fault[0]), .supply_fail_in(fault[1]), .underload_in(fault[2]),
		.overload_in(fault[3]), .high_side_output(hi), .low_side_output(lo),
		.overvoltage_lockout_enable(opt[2]), .underload_shutdown_enable(opt[1]),
		.overcurrent_delay_select(opt[0]));
	hbs_device u_hbs_device_b (.clock(clock), .sys_rst(sys_rst), .link(link_b.device),
		.thermal_warning_in(1'b0), .supply_fail_in(1'b0), .underload_in(1'b0),
		.overload_in(1'b0), .high_side_output(hi_b), .low_side_output(lo_b),
		.overvoltage_lockout_enable(), .underload_shutdown_enable(),
		.overcurrent_delay_select());
	hbs_link_monitor u_hbs_link_monitor (.clock(clock), .sys_rst(sys_rst),
		.enable(link.enable), .chip_select_n(link.chip_select_n), .sclk(link.sclk),
		.sdi(link.sdi), .sdo_oe(link.sdo_oe));
	initial forever #50 clock = ~clock;
	function automatic logic [15:0] drv(input logic [15:0] w);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 6; i++) begin
			r[i] = w[2 * i + 1];
			r[8 + i] = w[2 * i + 2];
		end
		return r;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [15:0] w, input bit b);
		@(negedge clock);
		chk(b ? {2'h0, hi_b, 2'h0, lo_b} : {2'h0, hi, 2'h0, lo}, drv(w));
		if (!b)
			chk({13'h0, opt}, {13'h0, w[15:13]});
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask
	task automatic send(input logic [15:0] w);
		logic [15:0] s;
		wr_reg(ADDR_TX, w);
		for (int i = 0; i < 400; i++) begin
			rd_reg(ADDR_STATUS, s);
			if (s[0] === 1'b0)
				break;
		end
		chk({15'h0000, s[0]}, 16'h0000);
		repeat (20) @(posedge clock);
	endtask
	task automatic frame_b(input logic [31:0] w, input int n);
		@(posedge clock);
		link_b.chip_select_n <= 1'b0;
		link_b.sdi <= w[0];
		repeat (4) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			link_b.sclk <= 1'b1;
			repeat (3) @(posedge clock);
			@(negedge clock);
			so_bits[i] = link_b.sdo;
			@(posedge clock);
			link_b.sclk <= 1'b0;
			repeat (3) @(posedge clock);
			link_b.sdi <= w[(i + 1) % 32];
			@(posedge clock);
		end
		link_b.chip_select_n <= 1'b1;
		link_b.sdi <= 1'b0;
		repeat (60) @(posedge clock);
	endtask
	always @(negedge clock) begin
		cyc <= cyc + 1;
		side_q <= sides;
		for (int i = 0; i < 12; i++) begin
			if (side_q[i] === 1'b1 && sides[i] === 1'b0)
				off_t[i] = cyc;
			if (side_q[i] === 1'b0 && sides[i] === 1'b1)
				chk(16'(cyc - off_t[(i + 6) % 12] >= DEAD_CYC), 16'h0001);
		end
	end
	initial begin
		logic [15:0] s;
		link_b.enable = 1'b1;
		link_b.chip_select_n = 1'b1;
		link_b.sclk = 1'b0;
		link_b.sdi = 1'b0;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		chk_out(16'h0000, 0);
		wr_reg(ADDR_CTRL, 16'h0001);
		fault <= 4'hF;
		rd_reg(ADDR_CTRL, s);
		chk(s, 16'h0001);
		send(16'hA132);
		chk_out(16'hA132, 0);
		rd_reg(ADDR_RX, s);
		chk(s, 16'hE001);
		send(16'hA134);
		chk_out(16'hA134, 0);
		rd_reg(ADDR_RX, s);
		chk(s, 16'hE133);
		fault <= 4'h0;
		send(16'hA135);
		chk_out(16'hA134, 0);
		send(16'h4134);
		chk_out(16'h4134, 0);
		rd_reg(ADDR_RX, s);
		chk(s, 16'h0134);
		wr_reg(ADDR_CTRL, 16'h0000);
		repeat (10) @(posedge clock);
		chk_out(16'h0000, 0);
		wr_reg(ADDR_TX, 16'h0002);
		repeat (10) @(posedge clock);
		chk({15'h0, link.chip_select_n}, 16'h0001);
		wr_reg(ADDR_CTRL, 16'h0001);
		repeat (10) @(posedge clock);
		chk_out(16'h0000, 0);
		frame_b(32'h0000_0002, 16);
		chk_out(16'h0002, 1);
		chk(so_bits[15:0], 16'h0000);
		frame_b(32'h0000_0008, 15);
		chk_out(16'h0002, 1);
		frame_b(32'h0000_0000, 0);
		chk_out(16'h0002, 1);
		frame_b(32'h0010_0008, 32);
		chk_out(16'h0010, 1);
		chk(so_bits[15:0], 16'h0002);
		chk(so_bits[31:16], 16'h0008);
		end_of_test();
	end
	initial begin
		repeat (30000) @(posedge clock);
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
